/* File: pkg/tlbi_pkg.sv */
// constants, register map and state encoding of the invalidate-by-address-any-space block
package tlbi_pkg;

    // ************************************************************
    // register map, byte offsets on the register bus
    // ************************************************************
    localparam logic [7:0] TLBI_OFS_INVAL_LO = 8'h00;
    localparam logic [7:0] TLBI_OFS_INVAL_HI = 8'h04;
    localparam logic [7:0] TLBI_OFS_BANK_CTRL = 8'h08;
    localparam logic [7:0] TLBI_OFS_STATUS = 8'h0C;
    localparam logic [7:0] TLBI_OFS_UPPER_STAGE = 8'h10;

    // ************************************************************
    // bank control fields
    // ************************************************************
    localparam int TLBI_CTRL_WIDE = 0;
    localparam int TLBI_CTRL_GRAN_LO = 1;
    localparam int TLBI_CTRL_SECURE = 3;
    localparam int TLBI_CTRL_HYP = 4;
    localparam int TLBI_CTRL_MON = 5;
    localparam int TLBI_CTRL_VMID_LO = 8;
    localparam int TLBI_VMID_W = 8;
    localparam logic [31:0] TLBI_CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] TLBI_CTRL_MASK = 32'h0000_FF3F;

    // granule encodings
    localparam logic [1:0] TLBI_GRAN_4K = 2'h0;
    localparam logic [1:0] TLBI_GRAN_16K = 2'h1;
    localparam logic [1:0] TLBI_GRAN_64K = 2'h2;

    // ************************************************************
    // status fields
    // ************************************************************
    localparam int TLBI_STAT_BUSY = 0;
    localparam int TLBI_STAT_S1 = 1;
    localparam int TLBI_STAT_IGN = 2;
    localparam int TLBI_STAT_CNT_LO = 8;

    // ************************************************************
    // address layout: tag holds address bits 63 down to 12
    // ************************************************************
    localparam int TLBI_VA_W = 52;
    localparam int TLBI_WIDE_ADDR_MSB = 43;
    localparam int TLBI_SIGN_W = 8;
    localparam int TLBI_NARROW_ADDR_LO = 12;
    localparam logic [51:0] TLBI_MASK_4K = 52'hF_FFFF_FFFF_FFFF;
    localparam logic [51:0] TLBI_MASK_16K = 52'hF_FFFF_FFFF_FFFC;
    localparam logic [51:0] TLBI_MASK_64K = 52'hF_FFFF_FFFF_FFF0;

    // ************************************************************
    // tag memory entry layout
    // ************************************************************
    localparam int TLBI_ENT_VA_LO = 0;
    localparam int TLBI_ENT_VMID_LO = 52;
    localparam int TLBI_ENT_SECURE = 60;
    localparam int TLBI_ENT_GLOBAL = 61;
    localparam int TLBI_ENT_LOCKED = 62;
    localparam int TLBI_ENT_W = 63;

    // bus responses
    localparam logic [1:0] TLBI_RESP_OKAY = 2'h0;
    localparam logic [1:0] TLBI_RESP_SLVERR = 2'h2;

    // walker states, gray along idle, read, check
    typedef enum logic [1:0] {
        TLBI_IDLE = 2'h0,
        TLBI_READ = 2'h1,
        TLBI_CHECK = 2'h3
    } tlbi_state_t;

endpackage : tlbi_pkg

/* File: rtl/tlbi_tag_ram.sv */
// tag memory of the translation cache with one write port and a registered read port
`timescale 1ns/10ps
module tlbi_tag_ram #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 63
) (
    input wire logic aclk,
    input wire logic ce,
    input wire logic we,
    input wire logic [$clog2(DEPTH)-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [$clog2(DEPTH)-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] mem [DEPTH];

    // write port
    always_ff @(posedge aclk) begin
        if (ce && we) begin
            mem[waddr] <= wdata;
        end
    end

    // read data leave through a register
    always_ff @(posedge aclk) begin
        if (ce) begin
            rdata <= mem[raddr];
        end
    end

endmodule : tlbi_tag_ram

/* File: rtl/tlbi_va_all_space.sv */
// invalidate-by-address-any-space maintenance register with its translation cache walker
`timescale 1ns/10ps
module tlbi_va_all_space
    import tlbi_pkg::*;
#(
    parameter int ENTRIES = 16,
    parameter bit STAGE1_SUPPORTED = 1'b1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic fill_valid,
    output logic fill_ready,
    input wire logic [$clog2(ENTRIES)-1:0] fill_index,
    input wire logic [TLBI_VA_W-1:0] fill_va,
    input wire logic [TLBI_VMID_W-1:0] fill_vmid,
    input wire logic fill_secure,
    input wire logic fill_global,
    input wire logic fill_locked,
    output logic [ENTRIES-1:0] entry_valid,
    output logic inval_done
);

    localparam int IDX_W = $clog2(ENTRIES);
    localparam int CNT_W = $clog2(ENTRIES + 1);
    localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(ENTRIES - 1);

    // ************************************************************
    // declarations
    // ************************************************************
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [31:0] strb_mask;
    logic [31:0] w_masked;
    logic wr_fire;
    logic [31:0] bank_ctrl;
    logic [31:0] upper_stage;
    logic upper_ok;
    logic ignored;
    logic start;
    logic inval_ignore;
    logic [63:0] inval_word;
    logic [TLBI_VA_W-1:0] next_target;
    logic [TLBI_VA_W-1:0] target;
    logic [TLBI_VA_W-1:0] gran_mask;
    logic [TLBI_VA_W-1:0] snap_mask;
    logic snap_secure;
    logic [TLBI_VMID_W-1:0] snap_vmid;
    tlbi_state_t state;
    tlbi_state_t next_state;
    logic [IDX_W-1:0] idx;
    logic [CNT_W-1:0] cnt;
    logic [TLBI_ENT_W-1:0] ent;
    logic [TLBI_ENT_W-1:0] fill_word;
    logic fill_take;
    logic hit;
    logic busy;
    logic [31:0] rd_value;
    logic [1:0] rd_resp;

    assign busy = (state != TLBI_IDLE);

    // ************************************************************
    // register bus write side
    // ************************************************************

    // address channel, stalled while a pass runs so one write gives one pass
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            s_axi_awready <= 1'b0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && (next_state == TLBI_IDLE);
        end
    end

    // data channel, taken in either order against the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_wready <= 1'b0;
        end else if (ce) begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
            s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
        end
    end

    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign strb_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    assign w_masked = w_data & strb_mask;

    // write response, slave error for an unmapped address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= TLBI_RESP_OKAY;
        end else if (ce) begin
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                if (aw_addr == TLBI_OFS_INVAL_LO || aw_addr == TLBI_OFS_INVAL_HI) begin
                    s_axi_bresp <= TLBI_RESP_OKAY;
                end else if (aw_addr == TLBI_OFS_BANK_CTRL || aw_addr == TLBI_OFS_STATUS) begin
                    s_axi_bresp <= TLBI_RESP_OKAY;
                end else if (aw_addr == TLBI_OFS_UPPER_STAGE) begin
                    s_axi_bresp <= TLBI_RESP_OKAY;
                end else begin
                    s_axi_bresp <= TLBI_RESP_SLVERR;
                end
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // bank control register, byte lanes honoured
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bank_ctrl <= TLBI_CTRL_RESET;
        end else if (ce) begin
            if (wr_fire && aw_addr == TLBI_OFS_BANK_CTRL) begin
                bank_ctrl <= ((bank_ctrl & ~strb_mask) | w_masked) & TLBI_CTRL_MASK;
            end
        end
    end

    // upper half staging: the next lower-half write forms one 64-bit access when the wide bit is set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            upper_stage <= 32'h0000_0000;
            upper_ok <= 1'b0;
        end else if (ce) begin
            if (wr_fire && aw_addr == TLBI_OFS_UPPER_STAGE) begin
                upper_stage <= w_masked;
                upper_ok <= 1'b1;
            end else if (wr_fire && aw_addr == TLBI_OFS_INVAL_LO) begin
                upper_ok <= 1'b0;
            end
        end
    end

    // ************************************************************
    // invalidation request decode
    // ************************************************************

    // a write to the upper half alone never reaches this point
    always_comb begin
        inval_word = {32'h0000_0000, w_masked};
        if (bank_ctrl[TLBI_CTRL_WIDE] && upper_ok) begin
            inval_word = {upper_stage, w_masked};
        end
    end

    // address bits 63 down to 12 as the tag compares them
    always_comb begin
        if (bank_ctrl[TLBI_CTRL_WIDE]) begin
            next_target = {{TLBI_SIGN_W{inval_word[TLBI_WIDE_ADDR_MSB]}},
                           inval_word[TLBI_WIDE_ADDR_MSB:0]};
        end else begin
            next_target = {32'h0000_0000, inval_word[31:TLBI_NARROW_ADDR_LO]};
        end
    end

    // granule decides how many low address bits take no part
    always_comb begin
        if (bank_ctrl[TLBI_CTRL_GRAN_LO +: 2] == TLBI_GRAN_64K) begin
            gran_mask = TLBI_MASK_64K;
        end else if (bank_ctrl[TLBI_CTRL_GRAN_LO +: 2] == TLBI_GRAN_16K) begin
            gran_mask = TLBI_MASK_16K;
        end else begin
            gran_mask = TLBI_MASK_4K;
        end
    end

    // unpredictable settings and a missing stage 1 make the write a no-op
    assign inval_ignore = !STAGE1_SUPPORTED || bank_ctrl[TLBI_CTRL_HYP] || bank_ctrl[TLBI_CTRL_MON];
    assign start = wr_fire && (aw_addr == TLBI_OFS_INVAL_LO) && !inval_ignore;

    // snapshot of target and bank settings for the whole pass
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            target <= '0;
            snap_mask <= TLBI_MASK_4K;
            snap_secure <= 1'b0;
            snap_vmid <= '0;
        end else if (ce) begin
            if (start) begin
                target <= next_target & gran_mask;
                snap_mask <= gran_mask;
                snap_secure <= bank_ctrl[TLBI_CTRL_SECURE];
                snap_vmid <= bank_ctrl[TLBI_CTRL_VMID_LO +: TLBI_VMID_W];
            end
        end
    end

    // remembers that the last request was dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ignored <= 1'b0;
        end else if (ce) begin
            if (wr_fire && aw_addr == TLBI_OFS_INVAL_LO) begin
                ignored <= inval_ignore;
            end
        end
    end

    // ************************************************************
    // walker over all entries
    // ************************************************************

    // next state of the walker
    always_comb begin
        next_state = state;
        case (state)
            TLBI_IDLE: begin
                if (start) begin
                    next_state = TLBI_READ;
                end
            end
            TLBI_READ: begin
                next_state = TLBI_CHECK;
            end
            TLBI_CHECK: begin
                if (idx == LAST_IDX) begin
                    next_state = TLBI_IDLE;
                end else begin
                    next_state = TLBI_READ;
                end
            end
            default: begin
                next_state = TLBI_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= TLBI_IDLE;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // entry index and count of removed entries
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idx <= '0;
            cnt <= '0;
        end else if (ce) begin
            if (start) begin
                idx <= '0;
                cnt <= '0;
            end else if (state == TLBI_CHECK) begin
                if (idx != LAST_IDX) begin
                    idx <= idx + 1'b1;
                end
                if (hit) begin
                    cnt <= cnt + 1'b1;
                end
            end
        end
    end

    // match ignores any space id, so global entries fall in as well
    always_comb begin
        hit = entry_valid[idx] && !ent[TLBI_ENT_LOCKED];
        if (((ent[TLBI_ENT_VA_LO +: TLBI_VA_W] & snap_mask) != target)) begin
            hit = 1'b0;
        end
        if (ent[TLBI_ENT_SECURE] != snap_secure) begin
            hit = 1'b0;
        end
        if (!snap_secure && ent[TLBI_ENT_VMID_LO +: TLBI_VMID_W] != snap_vmid) begin
            hit = 1'b0;
        end
    end

    // completion pulse at the end of every pass
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            inval_done <= 1'b0;
        end else if (ce) begin
            inval_done <= (state == TLBI_CHECK) && (idx == LAST_IDX);
        end else begin
            inval_done <= 1'b0;
        end
    end

    // ************************************************************
    // entry fill and valid bits
    // ************************************************************
    assign fill_take = fill_valid && fill_ready && (state == TLBI_IDLE);
    assign fill_word = {fill_locked, fill_global, fill_secure, fill_vmid, fill_va};

    // fills only between passes, so the two writers never meet
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fill_ready <= 1'b0;
        end else if (ce) begin
            fill_ready <= (next_state == TLBI_IDLE) && !start;
        end
    end

    // valid bit per entry, cleared by the walker on a hit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            entry_valid <= '0;
        end else if (ce) begin
            if (fill_take) begin
                entry_valid[fill_index] <= 1'b1;
            end else if (state == TLBI_CHECK && hit) begin
                entry_valid[idx] <= 1'b0;
            end
        end
    end

    tlbi_tag_ram #(
        .DEPTH(ENTRIES),
        .WIDTH(TLBI_ENT_W)
    ) u_tag_ram (
        .aclk(aclk),
        .ce(ce),
        .we(fill_take),
        .waddr(fill_index),
        .wdata(fill_word),
        .raddr(idx),
        .rdata(ent)
    );

    // ************************************************************
    // register bus read side
    // ************************************************************

    // read decode; the maintenance words read as zero
    always_comb begin
        rd_value = 32'h0000_0000;
        rd_resp = TLBI_RESP_OKAY;
        if (s_axi_araddr == TLBI_OFS_INVAL_LO || s_axi_araddr == TLBI_OFS_INVAL_HI) begin
            rd_value = 32'h0000_0000;
        end else if (s_axi_araddr == TLBI_OFS_UPPER_STAGE) begin
            rd_value = 32'h0000_0000;
        end else if (s_axi_araddr == TLBI_OFS_BANK_CTRL) begin
            rd_value = bank_ctrl;
        end else if (s_axi_araddr == TLBI_OFS_STATUS) begin
            rd_value[TLBI_STAT_BUSY] = busy;
            rd_value[TLBI_STAT_S1] = STAGE1_SUPPORTED;
            rd_value[TLBI_STAT_IGN] = ignored;
            rd_value[TLBI_STAT_CNT_LO +: 8] = 8'(cnt);
        end else begin
            rd_resp = TLBI_RESP_SLVERR;
        end
    end

    // one read at a time, data held until taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= TLBI_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_value;
                s_axi_rresp <= rd_resp;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end else if (!s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule : tlbi_va_all_space

/* File: bench/tlbi_va_all_space_monitor.sv */
// assertion checker bound to the invalidate-by-address-any-space block
`timescale 1ns/10ps
module tlbi_va_all_space_monitor #(
    parameter int ENTRIES = 16,
    parameter bit STAGE1_SUPPORTED = 1'b1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic fill_ready,
    input wire logic [ENTRIES-1:0] entry_valid,
    input wire logic inval_done
);
    // *****
    // bus and walker properties
    // *****
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_read_zero: assert property (s_axi_arvalid && s_axi_arready && (s_axi_araddr == 8'h00 || s_axi_araddr == 8'h04)
        |=> s_axi_rvalid && s_axi_rdata == 32'h0) else $error("maintenance read not zero");
    a_stage_flag: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h0C
        |=> s_axi_rdata[1] == STAGE1_SUPPORTED) else $error("stage 1 flag wrong");
    a_done_pulse: assert property (inval_done |=> !inval_done)
        else $error("done longer than one cycle");
    a_done_in_pass: assert property (inval_done |-> !$past(fill_ready))
        else $error("done without a pass");
    a_pass_bounded: assert property ($fell(fill_ready) |-> ##[1:80] inval_done)
        else $error("pass never ended");
    a_clear_in_pass: assert property ((|($past(entry_valid) & ~entry_valid)) |-> !$past(fill_ready))
        else $error("entry cleared outside a pass");
endmodule : tlbi_va_all_space_monitor
bind tlbi_va_all_space tlbi_va_all_space_monitor #(.ENTRIES(ENTRIES), .STAGE1_SUPPORTED(STAGE1_SUPPORTED)) i_mon (.*);

/* File: bench/tlbi_va_all_space_tb_top.sv */
// self-checking testbench of the invalidate-by-address-any-space block
`timescale 1ns/10ps
module tlbi_va_all_space_tb_top;
    import tlbi_pkg::*;
    localparam int ENT = 4;
    logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, fill_vmid = '0;
    logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp, fill_index = '0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, fill_ready, inval_done;
    logic fill_valid = 1'b0, fill_secure = 1'b0, fill_global = 1'b0, fill_locked = 1'b0;
    logic [51:0] fill_va = '0;
    logic [ENT-1:0] entry_valid;
    int miscompares = 0;
    int checks = 0;
    // *****
    // clock, design and helpers
    // *****
    always #12.5 aclk = ~aclk;
    tlbi_va_all_space #(.ENTRIES(ENT), .STAGE1_SUPPORTED(1'b1)) i_dut (.*);
    task automatic stop_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test
    task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected data at %0t: %h vs %h", $time, got, exp);
        end
    endtask : cmp_data
    task automatic cmp_valid(input logic [ENT-1:0] got, input logic [ENT-1:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected valid at %0t: %h vs %h", $time, got, exp);
        end
    endtask : cmp_valid
    // bounded wait ran out
    task automatic hang(input int n);
        if (n >= 200) begin
            miscompares++;
            stop_test();
        end
    endtask : hang
    // write with address and data offered together, response awaited
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        bit dn = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 200 && !dn; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            dn = s_axi_bvalid;
        end
        s_axi_bready <= 1'b0;
        cmp_data({30'h0, s_axi_bresp}, {30'h0, er});
        hang(n);
        @(posedge aclk);
    endtask : axi_write
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        int n;
        bit dn = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 200 && !dn; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            dn = s_axi_rvalid;
        end
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        cmp_data({30'h0, s_axi_rresp}, {30'h0, er});
        hang(n);
        @(posedge aclk);
    endtask : axi_read
    // load one cache entry; valid stays up for back-to-back loads
    task automatic fill(input int i, input logic [51:0] va, input logic [7:0] vm, input logic [2:0] f);
        int n;
        bit dn = 0;
        fill_valid <= 1'b1;
        fill_index <= i[1:0];
        fill_va <= va;
        fill_vmid <= vm;
        {fill_secure, fill_global, fill_locked} <= f;
        for (n = 0; n < 200 && !dn; n++) begin
            @(posedge aclk);
            dn = fill_ready;
        end
        hang(n);
    endtask : fill
    // *****
    // main sequence
    // *****
    initial begin
        logic [31:0] c, lo, hi, d;
        logic [63:0] r;
        logic [51:0] tg, mk, va;
        logic [ENT-1:0] ev;
        logic [2:0] f;
        logic [7:0] vm;
        logic ign;
        int n, k, cnt;
        k = $urandom(32'h3591);
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_read(TLBI_OFS_BANK_CTRL, d, TLBI_RESP_OKAY);
        cmp_data(d, TLBI_CTRL_RESET);
        axi_read(8'h20, d, TLBI_RESP_SLVERR);
        cmp_data(d, 32'h0);
        axi_write(8'h20, $urandom, TLBI_RESP_SLVERR);
        for (k = 0; k < 30; k++) begin
            c = $urandom & TLBI_CTRL_MASK;
            if (c[2:1] == 2'h3) c[1] = 1'b0;
            if ($urandom % 4 != 0) c[5:4] = 2'h0;
            lo = $urandom;
            hi = $urandom;
            axi_write(TLBI_OFS_BANK_CTRL, c, TLBI_RESP_OKAY);
            axi_read(TLBI_OFS_BANK_CTRL, d, TLBI_RESP_OKAY);
            cmp_data(d, c);
            axi_write(TLBI_OFS_INVAL_HI, $urandom, TLBI_RESP_OKAY);
            if (k[0]) axi_write(TLBI_OFS_UPPER_STAGE, hi, TLBI_RESP_OKAY);
            // expected target, mask and survivors
            r = {k[0] ? hi : 32'h0, lo};
            tg = c[0] ? {{8{r[43]}}, r[43:0]} : {32'h0, lo[31:12]};
            mk = (c[2:1] == 2'h2) ? ~52'hF : (c[2:1] == 2'h1) ? ~52'h3 : ~52'h0;
            ign = c[4] | c[5];
            ev = '1;
            cnt = 0;
            for (n = 0; n < ENT; n++) begin
                n[31:8] = 0;
                va = tg ^ ((($urandom % 4) == 0) ? 52'h0 : (52'h1 << ($urandom % 52)));
                vm = c[15:8] ^ (($urandom % 3) == 0);
                f = $urandom;
                fill(n, va, vm, f);
                if (!ign && !f[0] && f[2] == c[3] && (c[3] || vm == c[15:8]) && ((va ^ tg) & mk) == '0) begin
                    ev[n] = 1'b0;
                    cnt++;
                end
            end
            fill_valid <= 1'b0;
            axi_write(TLBI_OFS_INVAL_LO, lo, TLBI_RESP_OKAY);
            for (n = 0; n < 200 && !ign && inval_done !== 1'b1; n++) @(posedge aclk);
            hang(n);
            cmp_valid(entry_valid, ev);
            axi_read(TLBI_OFS_STATUS, d, TLBI_RESP_OKAY);
            cmp_data(d & (ign ? 32'h7 : 32'hFF07), {16'h0, ign ? 8'h0 : cnt[7:0], 5'h0, ign, 2'b10});
            axi_read(TLBI_OFS_INVAL_LO, d, TLBI_RESP_OKAY);
            cmp_data(d, 32'h0);
        end
        stop_test();
    end
endmodule : tlbi_va_all_space_tb_top
